// ### rtl/fsp_pkg.sv
// How it works
// - Protect: addr hi 0, mid 1, lo 0
// - Unprotect: addr hi 1, mid 1, lo 0
// - Suspend inside interval: rewait after resume
// - Suspend after interval: read at once
// - Poll at valid location being programmed
// - Reread complement bit after time limit flag
// - Two toggle reads differ means busy
// - Recheck toggle after time limit flag
package fsp_pkg;
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;
    localparam int CLK_MHZ = 100;
    localparam int POLL_US = 4;
    localparam int POLL_CYC = POLL_US * CLK_MHZ;
    localparam int RD_CYC = 12;
    localparam int WR_CYC = 10;
    localparam int BUF_WORDS = 16;
    localparam int BUF_BYTES = 32;
    localparam int SECTOR_ERASE_MS = 500;
    localparam int PROT_HI_BIT = 6;
    localparam int PROT_MID_BIT = 1;
    localparam int PROT_LO_BIT = 0;
    localparam int DCP_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int TLF_BIT = 5;
    localparam logic [DATA_W-1:0] RESET_CMD = 16'h00F0;
    typedef enum logic [6:0] {
        FSP_IDLE = 7'h01,
        FSP_WAIT = 7'h02,
        FSP_RD1 = 7'h04,
        FSP_RD2 = 7'h08,
        FSP_EVAL = 7'h10,
        FSP_WR = 7'h20,
        FSP_PROT = 7'h40
    } fsp_state_t;
    typedef enum logic [1:0] {
        FSP_POLL_DCP = 2'h0,
        FSP_POLL_TOG = 2'h1
    } fsp_mode_t;
endpackage

// ### rtl/fsp_host.sv
module fsp_host #(
    parameter int POLL_CYCLES = fsp_pkg::POLL_CYC
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic start,
    input wire logic use_toggle,
    input wire logic program_op,
    input wire logic suspended,
    input wire logic resumed,
    input wire logic prot_req,
    input wire logic prot_unprotect,
    input wire logic [fsp_pkg::ADDR_W-1:0] poll_addr,
    input wire logic [fsp_pkg::DATA_W-1:0] expect_data,
    input wire logic [fsp_pkg::DATA_W-1:0] flash_dq_in,
    input wire logic ready_busy_output,
    output logic [fsp_pkg::ADDR_W-1:0] flash_addr,
    output logic [fsp_pkg::DATA_W-1:0] flash_dq_out,
    output logic flash_dq_oe,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic busy,
    output logic done,
    output logic failed
);
    import fsp_pkg::*;

    initial begin
        if (POLL_CYCLES < 1 || POLL_CYCLES > 65535) $error("POLL_CYCLES out of range");
    end

    typedef struct packed {
        fsp_state_t st;
        logic [15:0] cnt;
        logic [15:0] poll_left;
        logic [DATA_W-1:0] first;
        logic [DATA_W-1:0] second;
        logic recheck;
        logic tog;
        logic interval_done;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq;
        logic oe_dq;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic busy;
        logic done;
        logic failed;
    } fsp_regs_t;

    fsp_regs_t s_reg;
    fsp_regs_t s_next;
    logic dcp_ok;
    logic toggling;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        dcp_ok = s_reg.second[DCP_BIT] == expect_data[DCP_BIT];
        toggling = s_reg.first[TOGGLE_BIT] != s_reg.second[TOGGLE_BIT];
        if (s_reg.poll_left != 16'h0000 && s_reg.st != FSP_IDLE && !suspended) begin
            s_next.poll_left = s_reg.poll_left - 16'h0001;
        end
        if (s_reg.poll_left == 16'h0001 && !suspended) begin
            s_next.interval_done = 1'b1;
        end
        // Resume before interval ran out restarts full wait
        if (resumed && !s_reg.interval_done && s_reg.st != FSP_IDLE) begin
            s_next.poll_left = POLL_CYCLES[15:0];
        end
        case (s_reg.st)
            FSP_IDLE: begin
                if (prot_req) begin
                    // Select lines held for the whole protect pulse
                    s_next.addr = '0;
                    s_next.addr[PROT_HI_BIT] = prot_unprotect;
                    s_next.addr[PROT_MID_BIT] = 1'b1;
                    s_next.addr[PROT_LO_BIT] = 1'b0;
                    s_next.ce_n = 1'b0;
                    s_next.we_n = 1'b0;
                    s_next.cnt = 16'(WR_CYC);
                    s_next.busy = 1'b1;
                    s_next.st = FSP_PROT;
                end else if (start) begin
                    s_next.addr = poll_addr;
                    s_next.tog = use_toggle;
                    s_next.recheck = 1'b0;
                    s_next.failed = 1'b0;
                    s_next.busy = 1'b1;
                    s_next.interval_done = !program_op;
                    s_next.poll_left = program_op ? POLL_CYCLES[15:0] : 16'h0000;
                    s_next.st = FSP_WAIT;
                end
            end
            FSP_WAIT: begin
                // Erase may last far beyond 0.5 s; no timeout here
                if (s_reg.poll_left == 16'h0000 && !suspended) begin
                    s_next.ce_n = 1'b0;
                    s_next.oe_n = 1'b0;
                    s_next.cnt = 16'(RD_CYC);
                    s_next.st = FSP_RD1;
                end
            end
            FSP_RD1, FSP_RD2: begin
                s_next.cnt = s_reg.cnt - 16'h0001;
                if (s_reg.st == FSP_RD2 && s_reg.cnt == 16'(RD_CYC + 1)) begin
                    // Idle cycle over, second toggle read starts
                    s_next.ce_n = 1'b0;
                    s_next.oe_n = 1'b0;
                end
                if (s_reg.cnt == 16'h0001) begin
                    s_next.oe_n = 1'b1;
                    s_next.ce_n = 1'b1;
                    s_next.first = s_reg.second;
                    s_next.second = flash_dq_in;
                    if (s_reg.st == FSP_RD1 && s_reg.tog) begin
                        // Strobes must rise between reads or the bit cannot move
                        s_next.st = FSP_RD2;
                        s_next.cnt = 16'(RD_CYC + 1);
                    end else begin
                        s_next.st = FSP_EVAL;
                    end
                end
            end
            FSP_EVAL: begin
                if (s_reg.tog ? !toggling : dcp_ok) begin
                    s_next.busy = 1'b0;
                    s_next.done = 1'b1;
                    s_next.st = FSP_IDLE;
                end else if (s_reg.second[TLF_BIT] && !s_reg.recheck) begin
                    s_next.recheck = 1'b1;
                    s_next.st = FSP_WAIT;
                end else if (s_reg.second[TLF_BIT]) begin
                    s_next.addr = '0;
                    s_next.dq = RESET_CMD;
                    s_next.oe_dq = 1'b1;
                    s_next.ce_n = 1'b0;
                    s_next.we_n = 1'b0;
                    s_next.cnt = 16'(WR_CYC);
                    s_next.st = FSP_WR;
                end else begin
                    s_next.st = FSP_WAIT;
                end
            end
            FSP_WR, FSP_PROT: begin
                s_next.cnt = s_reg.cnt - 16'h0001;
                if (s_reg.cnt == 16'h0001) begin
                    s_next.we_n = 1'b1;
                    s_next.ce_n = 1'b1;
                    s_next.oe_dq = 1'b0;
                    s_next.busy = 1'b0;
                    s_next.done = 1'b1;
                    s_next.failed = s_reg.st == FSP_WR;
                    s_next.st = FSP_IDLE;
                end
            end
            default: s_next.st = FSP_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= '{st: FSP_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign flash_addr = s_reg.addr;
    assign flash_dq_out = s_reg.dq;
    assign flash_dq_oe = s_reg.oe_dq;
    assign flash_ce_n = s_reg.ce_n;
    assign flash_oe_n = s_reg.oe_n;
    assign flash_we_n = s_reg.we_n;
    assign busy = s_reg.busy;
    assign done = s_reg.done;
    assign failed = s_reg.failed;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_prot_select: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_reg.st == FSP_PROT |-> flash_addr[PROT_MID_BIT] && !flash_addr[PROT_LO_BIT])
        else $error("protect select lines wrong");
    a_unprot_hi: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_reg.st == FSP_IDLE && prot_req |=> flash_addr[PROT_HI_BIT] == $past(prot_unprotect))
        else $error("unprotect high line wrong");
    a_no_early_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_reg.st == FSP_WAIT && s_next.st == FSP_RD1 |-> s_reg.interval_done)
        else $error("status read inside interval");
    a_no_read_susp: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_reg.st == FSP_WAIT && suspended |=> flash_oe_n)
        else $error("status read while suspended");
    a_fail_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_reg.st == FSP_WR |-> flash_dq_out == RESET_CMD && flash_dq_oe)
        else $error("failure without reset command");
    a_recheck_first: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_reg.st == FSP_EVAL && s_next.st == FSP_WR |-> s_reg.recheck)
        else $error("failed without recheck");
    a_toggle_pair: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_reg.st == FSP_RD1 && s_reg.tog && s_reg.cnt == 16'h0001
        |=> s_reg.st == FSP_RD2 && flash_oe_n)
        else $error("toggle needs second read");
    a_poll_addr: assert property (@(posedge clk_sys) disable iff (!reset_n)
        s_reg.st == FSP_IDLE && start && !prot_req |=> flash_addr == $past(poll_addr))
        else $error("poll address not kept");
    a_done_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
        done |=> !done && !busy)
        else $error("done not a pulse");
    c_pass: cover property (@(posedge clk_sys) done && !failed);
    c_fail: cover property (@(posedge clk_sys) done && failed);
    c_resume: cover property (@(posedge clk_sys) resumed && busy);
    c_recheck: cover property (@(posedge clk_sys) s_reg.st == FSP_EVAL && s_reg.recheck);
    c_unprotect: cover property (@(posedge clk_sys) s_reg.st == FSP_PROT && flash_addr[PROT_HI_BIT]);
endmodule

// ### dv/fsp_flash_model.sv
module fsp_flash_model (
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic [fsp_pkg::ADDR_W-1:0] flash_addr,
    input wire logic [fsp_pkg::DATA_W-1:0] flash_dq_out,
    input wire logic load,
    input wire logic stuck,
    input wire logic [7:0] busy_reads,
    input wire logic [fsp_pkg::DATA_W-1:0] final_data,
    output logic [fsp_pkg::DATA_W-1:0] flash_dq_in,
    output logic ready_busy_output,
    output logic [fsp_pkg::ADDR_W-1:0] rd_addr,
    output logic [fsp_pkg::ADDR_W-1:0] wr_addr,
    output logic [fsp_pkg::DATA_W-1:0] wr_data
);
    logic [fsp_pkg::DATA_W-1:0] st = 16'h0000;
    int left = 0;
    assign ready_busy_output = (left == 0) && !stuck;
    // Released bus shows the inverse, never a stale copy
    assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? st : ~st;
    always @(posedge load) left = busy_reads;
    always @(negedge flash_oe_n) begin
        if (!flash_ce_n) begin
            rd_addr = flash_addr;
            if (left > 0 || stuck) begin
                st[6] = ~st[6];
                st[7] = ~final_data[7];
                st[5] = stuck;
                if (left > 0) left--;
            end else st = final_data;
        end
    end
    // Any burst length is taken; one word kept
    always @(posedge flash_we_n) begin
        wr_addr = flash_addr;
        wr_data = flash_dq_out;
    end
endmodule

// ### dv/fsp_tb_top.sv
module fsp_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fsp_pkg::*;
    localparam int P = 4;
    logic clk_sys = 0;
    logic reset_n = 0;
    logic start = 0, use_toggle = 0, program_op = 0, suspended = 0, resumed = 0;
    logic prot_req = 0, prot_unprotect = 0, load = 0, stuck = 0;
    logic [7:0] busy_reads = 8'h00;
    logic [ADDR_W-1:0] poll_addr = 23'h012345;
    logic [DATA_W-1:0] expect_data = 16'h00A5;
    logic [ADDR_W-1:0] flash_addr, rd_addr, wr_addr;
    logic [DATA_W-1:0] flash_dq_in, flash_dq_out, wr_data;
    logic flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, ready_busy_output;
    logic busy, done, failed;
    int fail_count = 0;
    int n_compared = 0;
    fsp_host #(.POLL_CYCLES(P)) i_fsp_host (.clk_sys(clk_sys), .reset_n(reset_n),
        .start(start), .use_toggle(use_toggle), .program_op(program_op),
        .suspended(suspended), .resumed(resumed), .prot_req(prot_req),
        .prot_unprotect(prot_unprotect), .poll_addr(poll_addr), .expect_data(expect_data),
        .flash_dq_in(flash_dq_in), .ready_busy_output(ready_busy_output),
        .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
        .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
        .busy(busy), .done(done), .failed(failed));
    fsp_flash_model i_fsp_flash_model (.flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
        .flash_we_n(flash_we_n), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
        .load(load), .stuck(stuck), .busy_reads(busy_reads), .final_data(expect_data),
        .flash_dq_in(flash_dq_in), .ready_busy_output(ready_busy_output),
        .rd_addr(rd_addr), .wr_addr(wr_addr), .wr_data(wr_data));
    // ----------------
    // Tasks
    // ----------------
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Bounded so a lost done pulse cannot hang the run
    task automatic wait_done(output int k);
        k = 0;
        while (done !== 1'b1 && k < 5000) begin
            @(negedge clk_sys);
            k++;
        end
        check(done, 1);
    endtask
    task automatic poll(input logic tog, input logic stk, input logic [7:0] n);
        int k;
        @(negedge clk_sys);
        use_toggle = tog;
        stuck = stk;
        busy_reads = n;
        load = 1;
        start = 1;
        @(negedge clk_sys);
        load = 0;
        start = 0;
        wait_done(k);
        check(k >= P + RD_CYC, 1);
        check(failed, stk);
        check(rd_addr, poll_addr);
        if (stk) check(wr_data, RESET_CMD);
    endtask
    // ----------------
    // Sequence
    // ----------------
    initial begin
        int k;
        repeat (12) @(negedge clk_sys);
        reset_n = 1;
        program_op = 1;
        poll(0, 0, 8'h03);
        poll(1, 0, 8'h03);
        poll(0, 1, 8'h00);
        poll(1, 1, 8'h00);
        fork
            poll(0, 0, 8'h01);
            begin
                repeat (2) @(negedge clk_sys);
                suspended = 1;
                repeat (20) begin
                    @(negedge clk_sys);
                    check(flash_oe_n, 1);
                end
                suspended = 0;
                resumed = 1;
                @(negedge clk_sys);
                resumed = 0;
                repeat (P) begin
                    check(flash_oe_n, 1);
                    @(negedge clk_sys);
                end
                check(flash_oe_n, 1);
                @(negedge clk_sys);
                check(flash_oe_n, 0);
            end
        join
        // Suspend once the interval is over: no new wait on resume
        fork
            poll(0, 0, 8'h02);
            begin
                repeat (P + RD_CYC + 4) @(negedge clk_sys);
                suspended = 1;
                repeat (10) begin
                    @(negedge clk_sys);
                    check(flash_oe_n, 1);
                end
                suspended = 0;
                resumed = 1;
                @(negedge clk_sys);
                resumed = 0;
                check(flash_oe_n, 0);
            end
        join
        program_op = 0;
        poll(0, 0, 8'h28);
        for (int u = 0; u < 2; u++) begin
            @(negedge clk_sys);
            prot_unprotect = u[0];
            prot_req = 1;
            @(negedge clk_sys);
            prot_req = 0;
            wait_done(k);
            check(wr_addr[PROT_HI_BIT], u[0]);
            check(wr_addr[PROT_MID_BIT], 1);
            check(wr_addr[PROT_LO_BIT], 0);
        end
        complete_run();
    end
    initial begin
        #200000;
        fail_count++;
        complete_run();
    end
endmodule
